// ### drum_pkg.sv
// Constants, register map and bus carriers for the step sequencer
package drum_pkg;
  localparam int CLK_NS      = 25;
  localparam int TICK_NS     = 10_000_000;  // 0.01 s count tick
  localparam int SCAN_NS     = 1_000_000;   // Controller scan period
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int SCAN_CYCLES = SCAN_NS / CLK_NS;

  localparam int NSTEP = 16;
  localparam int NOUT  = 16;
  localparam logic [13:0] MAX4D = 14'h270f;  // 9999

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_TBASE  = 8'h04;
  localparam logic [7:0] OFF_PRESET = 8'h08;
  localparam logic [7:0] OFF_LAST   = 8'h0c;
  localparam logic [7:0] OFF_MASK   = 8'h10;
  localparam logic [7:0] OFF_STAT   = 8'h14;
  localparam logic [7:0] OFF_OUTS   = 8'h18;
  localparam logic [7:0] OFF_SCNT   = 8'h20;
  localparam logic [7:0] OFF_CTMR   = 8'h24;
  localparam logic [7:0] OFF_PSTEP  = 8'h28;
  localparam logic [7:0] OFF_CSTEP  = 8'h2c;
  localparam logic [1:0] TBL_PAT    = 2'h1;  // 0x40..0x7c
  localparam logic [1:0] TBL_CNT    = 2'h2;  // 0x80..0xbc
  localparam logic [1:0] TBL_EVC    = 2'h3;  // 0xc0..0xfc

  // Control fields
  localparam int CTL_RUN    = 0;
  localparam int CTL_START  = 1;
  localparam int CTL_JOG    = 2;
  localparam int CTL_RESET  = 3;
  localparam int CTL_NONRET = 4;
  localparam int CTL_VAR    = 8;  // two bits
  // Step event config fields
  localparam int EVC_SEL = 0;  // four bits
  localparam int EVC_TM  = 4;
  localparam int EVC_EV  = 5;

  // Reset values
  localparam logic [13:0] RST_TBASE  = 14'h0001;
  localparam logic [4:0]  RST_PRESET = 5'h01;
  localparam logic [4:0]  RST_LAST   = 5'h10;
  localparam logic [15:0] RST_MASK   = 16'hffff;
  localparam logic [5:0]  RST_EVC    = 6'h10;  // Timer only

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    VAR_TIMED, VAR_TIME_EVENT, VAR_MASK_BIT, VAR_MASK_WORD
  } variant_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;
endpackage

// ### drum_step_sequencer.sv
// Sixteen-step pattern sequencer with timer and event transitions
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module drum_step_sequencer #(
  parameter int TICK_CYCLES = drum_pkg::TICK_CYCLES,
  parameter int SCAN_CYCLES = drum_pkg::SCAN_CYCLES
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire drum_pkg::axil_req_t axi_req,
  output drum_pkg::axil_rsp_t      axi_rsp,
  input  wire logic [15:0]         event_in,
  output logic [15:0]              pattern_out,
  output logic                     done_out
);

  typedef enum logic { SEQ_RUN, SEQ_DONE } seq_t;

  typedef struct packed {
    logic [31:0]       tick_cnt;
    logic [31:0]       scan_cnt;
    logic              tick_pend;
    logic [15:0]       ev_s1;
    logic [15:0]       ev_s2;
    logic [15:0]       ctrl;
    logic [13:0]       tbase;
    logic [4:0]        preset;
    logic [4:0]        last;
    logic [15:0]       mask;
    logic [15:0][15:0] pat;
    logic [15:0][13:0] cnt;
    logic [15:0][5:0]  evc;
    logic [15:0]       scnt;
    logic [15:0]       ctmr;
    logic [4:0]        cur;
    seq_t              seq;
    logic              run_prev;
    logic              jog_prev;
    logic [15:0]       outp;
    logic              aw_ok;
    logic [7:0]        awaddr;
    logic              aw_bad;
    logic              w_ok;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  // Four-digit quantities saturate rather than wrap
  function automatic logic [13:0] clamp4d(input logic [31:0] v);
    clamp4d = (v > 32'(drum_pkg::MAX4D)) ? drum_pkg::MAX4D : v[13:0];
  endfunction

  function automatic logic [4:0] clamp_step(input logic [31:0] v);
    if (v == 32'h0)
      clamp_step = 5'h01;
    else if (v > 32'(drum_pkg::NSTEP))
      clamp_step = 5'h10;
    else
      clamp_step = v[4:0];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = wd[8*i +: 8];
      end
    end
  endfunction

  // Masked variants gate the pattern; plain variants pass it whole
  function automatic logic [15:0] drive(input state_t st, input logic [4:0] step);
    logic [15:0] p;
    p = st.pat[4'(step - 5'h01)];
    if (st.ctrl[drum_pkg::CTL_VAR +: 2] == 2'(drum_pkg::VAR_MASK_BIT) ||
        st.ctrl[drum_pkg::CTL_VAR +: 2] == 2'(drum_pkg::VAR_MASK_WORD)) begin
      p = p & st.mask;
    end
    drive = st.ctrl[drum_pkg::CTL_RUN] ? p : 16'h0000;
  endfunction

  function automatic logic [33:0] rd(input state_t st, input logic [31:0] a);
    logic [31:0] d;
    logic        bad;
    d   = 32'h0;
    bad = 1'b0;
    if (a[31:8] != 24'h0) begin
      bad = 1'b1;
    end else if (a[7:6] == drum_pkg::TBL_PAT) begin
      d[15:0] = st.pat[a[5:2]];
    end else if (a[7:6] == drum_pkg::TBL_CNT) begin
      d[13:0] = st.cnt[a[5:2]];
    end else if (a[7:6] == drum_pkg::TBL_EVC) begin
      d[5:0] = st.evc[a[5:2]];
    end else begin
      unique case ({a[7:2], 2'b00})
        drum_pkg::OFF_CTRL:   d[15:0] = st.ctrl;
        drum_pkg::OFF_TBASE:  d[13:0] = st.tbase;
        drum_pkg::OFF_PRESET: d[4:0]  = st.preset;
        drum_pkg::OFF_LAST:   d[4:0]  = st.last;
        drum_pkg::OFF_MASK:   d[15:0] = st.mask;
        drum_pkg::OFF_STAT:   d[0]    = (st.seq == SEQ_DONE);
        drum_pkg::OFF_OUTS:   d[15:0] = st.outp;
        drum_pkg::OFF_SCNT:   d[15:0] = st.scnt;
        drum_pkg::OFF_CTMR:   d[15:0] = st.ctmr;
        drum_pkg::OFF_PSTEP:  d[4:0]  = st.preset;
        drum_pkg::OFF_CSTEP:  d[4:0]  = st.cur;
        default:              bad     = 1'b1;
      endcase
    end
    rd = {bad, 1'b0, d};
  endfunction

  logic        tick;
  logic        scan;
  logic        tickp;
  logic        adv;
  logic        ev;
  logic [5:0]  kind;
  logic [31:0] wv;
  logic [33:0] rres;
  logic [1:0]  var_sel;

  always_comb begin
    nxt_s   = s_ff;
    adv     = 1'b0;
    ev      = 1'b0;
    kind    = 6'h00;
    wv      = 32'h0;
    rres    = 34'h0;
    var_sel = s_ff.ctrl[drum_pkg::CTL_VAR +: 2];

    nxt_s.ev_s1 = event_in;
    nxt_s.ev_s2 = s_ff.ev_s1;

    // Time base and scan strobes
    tick = (s_ff.tick_cnt == 32'(TICK_CYCLES - 1));
    scan = (s_ff.scan_cnt == 32'(SCAN_CYCLES - 1));
    nxt_s.tick_cnt = tick ? 32'h0 : s_ff.tick_cnt + 32'h1;
    nxt_s.scan_cnt = scan ? 32'h0 : s_ff.scan_cnt + 32'h1;
    // A tick landing on the scan edge is consumed, not lost
    tickp = tick | s_ff.tick_pend;
    nxt_s.tick_pend = scan ? 1'b0 : tickp;

    // Write channel: address and data taken in either order
    if (axi_req.awvalid && !s_ff.aw_ok && !s_ff.bvalid) begin
      nxt_s.aw_ok  = 1'b1;
      nxt_s.awaddr = axi_req.awaddr[7:0];
      nxt_s.aw_bad = (axi_req.awaddr[31:8] != 24'h0);
    end
    if (axi_req.wvalid && !s_ff.w_ok && !s_ff.bvalid) begin
      nxt_s.w_ok  = 1'b1;
      nxt_s.wdata = axi_req.wdata;
      nxt_s.wstrb = axi_req.wstrb;
    end
    if (s_ff.bvalid && axi_req.bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_ok && s_ff.w_ok) begin
      nxt_s.aw_ok  = 1'b0;
      nxt_s.w_ok   = 1'b0;
      nxt_s.bvalid = 1'b1;
      rres = rd(s_ff, {24'h0, s_ff.awaddr});
      wv   = merge(rres[31:0], s_ff.wdata, s_ff.wstrb);
      nxt_s.bresp = (s_ff.aw_bad || rres[33]) ? drum_pkg::RESP_SLVERR : drum_pkg::RESP_OKAY;
      if (!s_ff.aw_bad) begin
        if (s_ff.awaddr[7:6] == drum_pkg::TBL_PAT) begin
          nxt_s.pat[s_ff.awaddr[5:2]] = wv[15:0];
        end else if (s_ff.awaddr[7:6] == drum_pkg::TBL_CNT) begin
          nxt_s.cnt[s_ff.awaddr[5:2]] = clamp4d(wv);
        end else if (s_ff.awaddr[7:6] == drum_pkg::TBL_EVC) begin
          nxt_s.evc[s_ff.awaddr[5:2]] = wv[5:0];
        end else begin
          unique case ({s_ff.awaddr[7:2], 2'b00})
            drum_pkg::OFF_CTRL:   nxt_s.ctrl   = {6'h00, wv[9:8], 3'h0, wv[4:0]};
            drum_pkg::OFF_TBASE:  nxt_s.tbase  = (wv == 32'h0) ? 14'h0001 : clamp4d(wv);
            drum_pkg::OFF_PRESET: nxt_s.preset = clamp_step(wv);
            drum_pkg::OFF_LAST:   nxt_s.last   = clamp_step(wv);
            drum_pkg::OFF_MASK:   nxt_s.mask   = wv[15:0];
            default:              nxt_s.mask   = s_ff.mask;
          endcase
        end
      end
    end

    // Read channel: one cycle from address to data
    if (s_ff.rvalid && axi_req.rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !s_ff.rvalid) begin
      rres = rd(s_ff, axi_req.araddr);
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata  = rres[31:0];
      nxt_s.rresp  = rres[33] ? drum_pkg::RESP_SLVERR : drum_pkg::RESP_OKAY;
    end

    // Sequencer, evaluated only on the scan strobe
    if (scan) begin
      nxt_s.run_prev = s_ff.ctrl[drum_pkg::CTL_RUN];
      nxt_s.jog_prev = s_ff.ctrl[drum_pkg::CTL_JOG];
      if (!s_ff.ctrl[drum_pkg::CTL_RUN]) begin
        nxt_s.seq = s_ff.seq;
      end else if (!s_ff.run_prev) begin
        // Retentive entry resumes where it stopped
        if (s_ff.ctrl[drum_pkg::CTL_NONRET]) begin
          nxt_s.scnt = 16'h0000;
          nxt_s.ctmr = 16'h0000;
          nxt_s.cur  = s_ff.preset;
          nxt_s.seq  = SEQ_RUN;
        end
      end else if (s_ff.ctrl[drum_pkg::CTL_RESET]) begin
        nxt_s.cur  = s_ff.preset;
        nxt_s.scnt = 16'h0000;
        nxt_s.ctmr = 16'h0000;
        nxt_s.seq  = SEQ_RUN;
      end else if (s_ff.seq == SEQ_RUN) begin
        if (s_ff.ctrl[drum_pkg::CTL_JOG] && !s_ff.jog_prev &&
            var_sel != 2'(drum_pkg::VAR_TIMED)) begin
          adv = 1'b1;
        end else if (s_ff.ctrl[drum_pkg::CTL_START]) begin
          kind = s_ff.evc[4'(s_ff.cur - 5'h01)];
          // No criteria, or the timed variant, falls back to timer only
          if (var_sel == 2'(drum_pkg::VAR_TIMED) ||
              !(kind[drum_pkg::EVC_TM] || kind[drum_pkg::EVC_EV])) begin
            kind = drum_pkg::RST_EVC;
          end
          ev = s_ff.ev_s2[kind[drum_pkg::EVC_SEL +: 4]];
          if (!kind[drum_pkg::EVC_EV] || ev) begin
            if (!kind[drum_pkg::EVC_TM]) begin
              adv = 1'b1;
            end else if (tickp) begin
              if (s_ff.ctmr + 16'h1 >= 16'(s_ff.tbase)) begin
                nxt_s.ctmr = 16'h0000;
                if (s_ff.scnt + 16'h1 >= 16'(s_ff.cnt[4'(s_ff.cur - 5'h01)])) begin
                  adv = 1'b1;
                end else begin
                  nxt_s.scnt = s_ff.scnt + 16'h1;
                end
              end else begin
                nxt_s.ctmr = s_ff.ctmr + 16'h1;
              end
            end
          end
        end
        if (adv) begin
          nxt_s.scnt = 16'h0000;
          nxt_s.ctmr = 16'h0000;
          if (s_ff.cur == s_ff.last || s_ff.cur == 5'(drum_pkg::NSTEP)) begin
            nxt_s.seq = SEQ_DONE;
          end else begin
            nxt_s.cur = s_ff.cur + 5'h01;
          end
        end
      end
    end

    // Pattern follows the new step in the same evaluation
    nxt_s.outp = drive(nxt_s, nxt_s.cur);

    axi_rsp.awready = !s_ff.aw_ok && !s_ff.bvalid;
    axi_rsp.wready  = !s_ff.w_ok && !s_ff.bvalid;
    axi_rsp.bvalid  = s_ff.bvalid;
    axi_rsp.bresp   = s_ff.bresp;
    axi_rsp.arready = !s_ff.rvalid;
    axi_rsp.rvalid  = s_ff.rvalid;
    axi_rsp.rdata   = s_ff.rdata;
    axi_rsp.rresp   = s_ff.rresp;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff        <= '0;
      s_ff.tbase  <= drum_pkg::RST_TBASE;
      s_ff.preset <= drum_pkg::RST_PRESET;
      s_ff.last   <= drum_pkg::RST_LAST;
      s_ff.mask   <= drum_pkg::RST_MASK;
      s_ff.evc    <= {drum_pkg::NSTEP{drum_pkg::RST_EVC}};
      s_ff.cur    <= drum_pkg::RST_PRESET;
      s_ff.seq    <= SEQ_RUN;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pattern_out = s_ff.outp;
  assign done_out    = (s_ff.seq == SEQ_DONE);

endmodule // drum_step_sequencer

// ### drum_step_sequencer_assertions.sv
// Concurrent checks on the step sequencer's ports
`timescale 1ns/100ps
module drum_step_sequencer_checker #(
  parameter int TICK_CYCLES = 4,
  parameter int SCAN_CYCLES = 2
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire drum_pkg::axil_req_t axi_req,
  input wire drum_pkg::axil_rsp_t axi_rsp,
  input wire logic [15:0]         event_in,
  input wire logic [15:0]         pattern_out,
  input wire logic                done_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic aw_go;
  logic ar_go;
  assign aw_go = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  assign ar_go = axi_req.arvalid && axi_rsp.arready;

  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !axi_rsp.bvalid && !axi_rsp.rvalid && pattern_out == 16'h0000 && !done_out) else $error("outputs live in reset");
  a_b_follows: assert property (aw_go |-> ##[1:2] axi_rsp.bvalid)
    else $error("write response missing");
  a_b_holds: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  a_r_follows: assert property (ar_go |=> axi_rsp.rvalid)
    else $error("read data late");
  a_r_holds: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while busy");
  a_aw_blocked: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while busy");
  a_unmapped_rd: assert property (ar_go && axi_req.araddr[31:8] != 24'h0 |=>
    axi_rsp.rresp == drum_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0) else $error("unmapped read accepted");
  a_done_pattern: assert property (done_out && $past(done_out) |-> $stable(pattern_out))
    else $error("pattern moved while complete");
  a_done_spacing: assert property ($changed(done_out) |=> $stable(done_out))
    else $error("complete flag moved between scans");

  cover property (aw_go);
  cover property ($rose(done_out));
  cover property ($fell(done_out));
endmodule // drum_step_sequencer_checker

bind drum_step_sequencer drum_step_sequencer_checker #(.TICK_CYCLES(TICK_CYCLES), .SCAN_CYCLES(SCAN_CYCLES)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .event_in(event_in), .pattern_out(pattern_out), .done_out(done_out));

// ### drum_event_source.sv
// Field event sources feeding the per-step event inputs
`timescale 1ns/100ps
module drum_event_source (
  input  wire logic        aclk,
  input  wire logic [15:0] want,
  input  wire logic [3:0]  lag,
  output logic [15:0]      event_in
);
  logic [15:0] pend_ff;
  logic [3:0]  wait_ff;
  initial begin
    event_in = 16'h0000;
    pend_ff = 16'h0000;
    wait_ff = 4'h0;
  end
  // Slow contacts settle lag+1 cycles after a change is seen
  always @(posedge aclk) begin
    if (want !== pend_ff) begin
      pend_ff <= want;
      wait_ff <= lag;
    end else if (wait_ff != 4'h0) begin
      wait_ff <= wait_ff - 4'h1;
    end else begin
      event_in <= pend_ff;
    end
  end
endmodule // drum_event_source

// ### drum_step_sequencer_tb_top.sv
// Self-checking bench for the step sequencer
`timescale 1ns/100ps
module drum_step_sequencer_tb_top;
  logic                aclk;
  logic                aresetn;
  drum_pkg::axil_req_t req;
  drum_pkg::axil_rsp_t rsp;
  logic [15:0]         want;
  logic [15:0]         ev;
  logic [15:0]         pattern_out;
  logic                done_out;
  logic [33:0]         exp_q[$];
  int                  n_mismatch;
  int                  total_checks;
  logic [15:0]         pat[16];
  logic [15:0]         msk;
  logic [31:0]         ctl;

  drum_step_sequencer #(.TICK_CYCLES(4), .SCAN_CYCLES(2)) dut (.aclk(aclk), .aresetn(aresetn),
    .axi_req(req), .axi_rsp(rsp), .event_in(ev), .pattern_out(pattern_out), .done_out(done_out));
  drum_event_source src (.aclk(aclk), .want(want), .lag(4'h3), .event_in(ev));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] exp_v);
    total_checks++;
    if (seen !== exp_v) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp_v);
    end
  endtask

  // Results are judged here, in the order they were requested
  always @(negedge aclk) begin
    if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
      if (exp_q.size() == 0)
        check(34'h0, 34'h1);
      else if (req.bready)
        check({rsp.bresp, 32'h0}, exp_q.pop_front());
      else
        check({rsp.rresp, rsp.rdata}, exp_q.pop_front());
    end
  end

  // Handshakes are judged at the falling edge, acted on after the next rise
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [33:0] e);
    int n;
    logic aw_t, w_t, ar_t, end_t, up_t, slow;
    exp_q.push_back(e);
    // A late ready now and then keeps the held-answer path busy
    slow = 1'($urandom);
    @(posedge aclk);
    req.awvalid <= wr;
    req.wvalid <= wr;
    req.bready <= wr && !slow;
    req.awaddr <= a;
    req.wdata <= d;
    req.arvalid <= !wr;
    req.rready <= !wr && !slow;
    req.araddr <= a;
    for (n = 0; n < 200; n++) begin
      @(negedge aclk);
      aw_t = req.awvalid && rsp.awready;
      w_t = req.wvalid && rsp.wready;
      ar_t = req.arvalid && rsp.arready;
      end_t = (req.bready && rsp.bvalid) || (req.rready && rsp.rvalid);
      up_t = (wr && rsp.bvalid) || (!wr && rsp.rvalid);
      @(posedge aclk);
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
      if (ar_t) req.arvalid <= 1'b0;
      if (end_t) begin
        req.bready <= 1'b0;
        req.rready <= 1'b0;
        break;
      end
      if (up_t) begin
        req.bready <= wr;
        req.rready <= !wr;
      end
    end
    if (n == 200) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = drum_pkg::RESP_OKAY);
    bus(1'b1, a, d, {r, 32'h0});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, {2'h0, e});
  endtask
  task automatic setc(input logic [31:0] v);
    ctl = v;
    wr(drum_pkg::OFF_CTRL, v);
  endtask
  task automatic jog(input int k);
    repeat (k) begin
      setc(ctl | 32'h4);
      setc(ctl & ~32'h4);
    end
    repeat (4) @(posedge aclk);
  endtask
  task automatic step_is(input logic [4:0] s);
    rd(drum_pkg::OFF_CSTEP, {27'h0, s});
    // Away from the launching edge
    @(negedge aclk);
    check({18'h0, pattern_out}, {18'h0, pat[s - 5'd1] & msk});
  endtask

  initial begin
    req = '0;
    req.wstrb = 4'hf;
    aresetn = 1'b0;
    want = 16'h0000;
    n_mismatch = 0;
    total_checks = 0;
    msk = 16'hffff;
    ctl = 32'h0;
    void'($urandom(32'h012f));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(drum_pkg::OFF_CTRL, 32'h0);
    rd(drum_pkg::OFF_TBASE, 32'h1);
    rd(drum_pkg::OFF_PRESET, 32'h1);
    rd(drum_pkg::OFF_LAST, 32'h10);
    rd(drum_pkg::OFF_MASK, 32'hffff);
    rd(drum_pkg::OFF_STAT, 32'h0);
    rd(drum_pkg::OFF_PSTEP, 32'h1);
    rd(drum_pkg::OFF_SCNT, 32'h0);
    rd(drum_pkg::OFF_CTMR, 32'h0);
    bus(1'b1, 32'h100, 32'h1, {drum_pkg::RESP_SLVERR, 32'h0});
    bus(1'b0, 32'h104, 32'h0, {drum_pkg::RESP_SLVERR, 32'h0});
    rd(drum_pkg::OFF_CTRL, 32'h0);
    bus(1'b0, 8'h1c, 32'h0, {drum_pkg::RESP_SLVERR, 32'h0});
    wr(8'h30, 32'h5, drum_pkg::RESP_SLVERR);
    wr(drum_pkg::OFF_PSTEP, 32'h7);
    rd(drum_pkg::OFF_PSTEP, 32'h1);
    wr(8'h80, 32'hffff);
    rd(8'h80, 32'h270f);
    for (int i = 0; i < 16; i++) begin
      pat[i] = 16'($urandom);
      wr(8'h40 + 8'(4 * i), {16'h0, pat[i]});
      wr(8'hc0 + 8'(4 * i), 32'h2f);
    end
    wr(drum_pkg::OFF_TBASE, 32'h3);
    wr(8'h8c, 32'h2);
    wr(8'hcc, 32'h35);
    setc(32'h101);
    repeat (4) @(posedge aclk);
    step_is(5'd1);
    jog(3);
    step_is(5'd4);
    setc(32'h103);
    repeat (60) @(posedge aclk);
    step_is(5'd4);
    want <= 16'h0020;
    repeat (8) @(posedge aclk);
    rd(drum_pkg::OFF_CSTEP, 32'h4);
    repeat (80) @(posedge aclk);
    step_is(5'd5);
    rd(drum_pkg::OFF_SCNT, 32'h0);
    rd(drum_pkg::OFF_CTMR, 32'h0);
    setc(32'h101);
    want <= 16'h8020;
    repeat (40) @(posedge aclk);
    step_is(5'd5);
    wr(drum_pkg::OFF_PRESET, 32'h3);
    setc(32'h10b);
    repeat (40) @(posedge aclk);
    step_is(5'd3);
    rd(drum_pkg::OFF_PSTEP, 32'h3);
    setc(32'h103);
    repeat (300) @(posedge aclk);
    step_is(5'd16);
    check({33'h0, done_out}, {33'h0, 1'b1});
    jog(1);
    step_is(5'd16);
    rd(drum_pkg::OFF_STAT, 32'h1);
    setc(32'h10b);
    repeat (8) @(negedge aclk);
    check({33'h0, done_out}, 34'h0);
    step_is(5'd3);
    setc(32'h201);
    msk = 16'($urandom);
    wr(drum_pkg::OFF_MASK, {16'h0, msk});
    repeat (4) @(posedge aclk);
    step_is(5'd3);
    jog(2);
    setc(32'h210);
    setc(32'h211);
    repeat (4) @(posedge aclk);
    step_is(5'd3);
    rd(drum_pkg::OFF_SCNT, 32'h0);
    jog(1);
    setc(32'h300);
    setc(32'h301);
    repeat (4) @(posedge aclk);
    step_is(5'd4);
    msk = 16'hffff;
    setc(32'h001);
    jog(1);
    step_is(5'd4);
    close_out();
  end
endmodule // drum_step_sequencer_tb_top
